// ===== le_ctrl_pkg.sv
package le_ctrl_pkg;

    // Number of logic elements handled by this block
    localparam int unsigned ELEM_COUNT = 8;
    // Dedicated low-skew inputs
    localparam int unsigned DED_COUNT  = 6;
    localparam int unsigned SYNC_WIDTH = 5 * ELEM_COUNT + DED_COUNT + 1;

    // APB register byte addresses
    localparam logic [7:0] MODE_LO_ADDR = 8'h00;
    localparam logic [7:0] MODE_HI_ADDR = 8'h04;
    localparam logic [7:0] CTRL_ADDR    = 8'h08;
    localparam logic [7:0] STATUS_ADDR  = 8'h0C;

    // Clear and preset mode codes, one per element
    localparam logic [2:0] MODE_CLEAR        = 3'h0;
    localparam logic [2:0] MODE_PRESET       = 3'h1;
    localparam logic [2:0] MODE_CLEAR_PRESET = 3'h2;
    localparam logic [2:0] MODE_LOAD_CLEAR   = 3'h3;
    localparam logic [2:0] MODE_LOAD_PRESET  = 3'h4;
    localparam logic [2:0] MODE_LOAD_ONLY    = 3'h5;

    // Per-element configuration byte
    typedef struct packed {
        logic       spare;
        logic       cen_use;     // Take enable from the clock-enable data input
        logic       rst_one;     // Chip reset sets instead of clears, in preset-capable modes only
        logic       preset_inv;  // Preset via inverted register and clear
        logic       clr_sel;     // Clear mode: 0 first line, 1 second line
        logic [2:0] mode;
    } elem_cfg_t;

    // Per-element inputs from user logic and routing
    typedef struct packed {
        logic data_in;
        logic clock_enable_data_input;
        logic async_load_data_input;
        logic block_control_line_first_n;
        logic block_control_line_second_n;
    } elem_pins_t;

    // Global control register
    typedef struct packed {
        logic [21:0] spare;
        logic [2:0]  glob_cen_sel;   // Values of DED_COUNT and above select none
        logic [2:0]  glob_pre_sel;
        logic [2:0]  glob_clr_sel;
        logic        chip_reset_en;
    } ctrl_t;

    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0FFE;

endpackage

// ===== le_ctrl_properties.sv
`timescale 1ns/1ps
module le_ctrl_properties (
    input wire logic                                    pclk,
    input wire logic                                    presetn,
    input wire logic                                    psel,
    input wire logic                                    penable,
    input wire logic                                    pwrite,
    input wire logic [7:0]                              paddr,
    input wire logic [31:0]                             pwdata,
    input wire logic [31:0]                             prdata,
    input wire logic                                    pready,
    input wire logic                                    pslverr,
    input wire le_ctrl_pkg::elem_pins_t [7:0]           elem_pins,
    input wire logic [5:0]                              dedicated_in,
    input wire logic                                    chip_reset_n,
    input wire logic [7:0]                              elem_q,
    input wire logic [5:0]                              dedicated_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [63:0] cfg_reg;
    logic        en_reg;
    logic        glob_off;
    logic [1:0]  up_reg;
    logic [7:0]  rst_exp;
    wire         acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg <= 64'h0000_0000_0000_0000;
            en_reg  <= 1'b0;
            glob_off <= 1'b1;
            up_reg  <= 2'h0;
        end else begin
            up_reg <= (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
            if (acc && pwrite && pready && paddr == le_ctrl_pkg::MODE_LO_ADDR) cfg_reg[31:0] <= pwdata;
            if (acc && pwrite && pready && paddr == le_ctrl_pkg::MODE_HI_ADDR) cfg_reg[63:32] <= pwdata;
            if (acc && pwrite && pready && paddr == le_ctrl_pkg::CTRL_ADDR) begin
                en_reg   <= pwdata[0];
                // Select codes of six and up pick no dedicated input
                glob_off <= &{pwdata[9:8], pwdata[6:5], pwdata[3:2]};
            end
        end
    end
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && paddr > le_ctrl_pkg::STATUS_ADDR |->
        pslverr && (pwrite || prdata == 32'h0000_0000)) else $error("unmapped access");
    a_mapped_ok: assert property (acc && paddr <= le_ctrl_pkg::STATUS_ADDR |-> !pslverr)
        else $error("error on mapped access");
    a_status_q: assert property (acc && !pwrite && paddr == le_ctrl_pkg::STATUS_ADDR
        |-> prdata[7:0] == $past(elem_q)) else $error("status q mismatch");
    a_ded_sync: assert property (up_reg == 2'h3 |-> dedicated_data == $past(dedicated_in, 2))
        else $error("dedicated data mismatch");
    a_chip_reset: assert property ((en_reg && !chip_reset_n)[*5] |-> elem_q == rst_exp)
        else $error("chip reset value");
    for (genvar i = 0; i < 8; i++) begin : g_el
        le_ctrl_pkg::elem_cfg_t c;
        le_ctrl_pkg::elem_pins_t p;
        wire quiet = !en_reg || chip_reset_n;
        assign c = cfg_reg[8*i +: 8];
        assign p = elem_pins[i];
        // Chip reset gives one only for preset-capable modes
        assign rst_exp[i] = c.rst_one && (c.mode == 3'h1 || c.mode == 3'h2 || c.mode == 3'h4);
        a_clear_first: assert property ((c.mode == le_ctrl_pkg::MODE_CLEAR && !c.clr_sel
            && !p.block_control_line_first_n)[*5] |-> !elem_q[i]) else $error("clear failed");
        a_load_only: assert property ((c.mode == le_ctrl_pkg::MODE_LOAD_ONLY && quiet
            && !p.block_control_line_first_n && $stable(p.async_load_data_input))[*5]
            |-> elem_q[i] == p.async_load_data_input) else $error("load failed");
        a_data_capture: assert property ((c.mode == le_ctrl_pkg::MODE_CLEAR && !c.cen_use
            && quiet && glob_off && p.block_control_line_first_n && p.block_control_line_second_n
            && $stable(p.data_in))[*5] |-> elem_q[i] == p.data_in) else $error("capture failed");
        a_enable_hold: assert property ((c.cen_use && !p.clock_enable_data_input && quiet
            && glob_off && p.block_control_line_first_n && p.block_control_line_second_n)[*5]
            |-> $stable(elem_q[i])) else $error("disabled register changed");
    end
endmodule // le_ctrl_properties
bind le_register_async_control le_ctrl_properties chk_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .elem_pins, .dedicated_in,
    .chip_reset_n, .elem_q, .dedicated_data);

// ===== le_register_async_control.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Function
// - Clear and preset come only from load data and two control lines
// - Controls are active low; unused ones sit high and never act
// - Six exclusive modes chosen by configuration
// - Load modes: first line copies load data into register three edges late
// - Clear mode: chosen line clears, preset held inactive
// - Preset as load: load data forced high, first line sets one
// - Alternative preset: clear with inverted data and output
// - Single-line inverted preset leaves load data input unused
// - Clear and preset: first line sets one, second clears
// - Load with clear: first loads via both, second drives clear only
// - Load with preset: inverted register, second presets, first loads inverted
// - Load only: first line loads through preset and clear
// - Enabled chip reset overrides every other control
// - Preset-capable registers may reset to one
// - Six dedicated inputs usable as global clear, preset, enable or data
// - Synchronous clock enable, optionally from the enable data input
module le_register_async_control (
    input  wire logic                                         pclk,
    input  wire logic                                         presetn,
    input  wire logic                                         psel,
    input  wire logic                                         penable,
    input  wire logic                                         pwrite,
    input  wire logic [7:0]                                   paddr,
    input  wire logic [31:0]                                  pwdata,
    output logic      [31:0]                                  prdata,
    output logic                                              pready,
    output logic                                              pslverr,
    input  wire le_ctrl_pkg::elem_pins_t [le_ctrl_pkg::ELEM_COUNT-1:0] elem_pins,
    input  wire logic [le_ctrl_pkg::DED_COUNT-1:0]            dedicated_in,
    input  wire logic                                         chip_reset_n,
    output logic      [le_ctrl_pkg::ELEM_COUNT-1:0]           elem_q,
    output logic      [le_ctrl_pkg::DED_COUNT-1:0]            dedicated_data
);

    localparam int unsigned N = le_ctrl_pkg::ELEM_COUNT;
    localparam int unsigned W = le_ctrl_pkg::SYNC_WIDTH;

    // Controls act three edges late, but no flop is reset by logic
    // Two-stage synchroniser for every pin input
    logic [W-1:0] sync1_reg;
    logic [W-1:0] sync2_reg;
    logic [W-1:0] pins_raw;

    assign pins_raw = {chip_reset_n, dedicated_in, elem_pins};

    // Reset value keeps active-low controls inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= {W{1'b1}};
            sync2_reg <= {W{1'b1}};
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end

    le_ctrl_pkg::elem_pins_t [N-1:0]           pins_s;
    logic [le_ctrl_pkg::DED_COUNT-1:0]         ded_s;
    logic                                      chip_reset_n_s;

    assign pins_s         = sync2_reg[5*N-1:0];
    assign ded_s          = sync2_reg[W-2 -: le_ctrl_pkg::DED_COUNT];
    assign chip_reset_n_s = sync2_reg[W-1];

    assign dedicated_data = ded_s;

    // Configuration registers
    logic [31:0]        mode_lo_reg;
    logic [31:0]        mode_lo_next;
    logic [31:0]        mode_hi_reg;
    logic [31:0]        mode_hi_next;
    le_ctrl_pkg::ctrl_t ctrl_reg;
    le_ctrl_pkg::ctrl_t ctrl_next;
    logic [31:0]        prdata_reg;
    logic [31:0]        prdata_next;
    logic [N-1:0]       store_reg;
    logic [N-1:0]       store_next;

    le_ctrl_pkg::elem_cfg_t [N-1:0] cfg;

    // Element k takes byte k of the low word, then the high word
    assign cfg = {mode_hi_reg, mode_lo_reg};

    // APB decode
    logic wr_access;
    logic setup;
    logic addr_hit;

    assign wr_access = psel && penable && pwrite;
    assign setup     = psel && !penable;
    assign addr_hit  = (paddr == le_ctrl_pkg::MODE_LO_ADDR) ||
                       (paddr == le_ctrl_pkg::MODE_HI_ADDR) ||
                       (paddr == le_ctrl_pkg::CTRL_ADDR)    ||
                       (paddr == le_ctrl_pkg::STATUS_ADDR);
    // No wait states, so a master never stalls
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_hit;
    assign prdata    = prdata_reg;

    always_comb begin
        mode_lo_next = mode_lo_reg;
        mode_hi_next = mode_hi_reg;
        ctrl_next    = ctrl_reg;
        prdata_next  = prdata_reg;
        if (wr_access) begin
            case (paddr)
                le_ctrl_pkg::MODE_LO_ADDR: begin
                    mode_lo_next = pwdata;
                end
                le_ctrl_pkg::MODE_HI_ADDR: begin
                    mode_hi_next = pwdata;
                end
                le_ctrl_pkg::CTRL_ADDR: begin
                    ctrl_next = {22'h00_0000, pwdata[9:0]};
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
        // Read data captured in setup so it leaves a flip-flop
        if (setup) begin
            case (paddr)
                le_ctrl_pkg::MODE_LO_ADDR: begin
                    prdata_next = mode_lo_reg;
                end
                le_ctrl_pkg::MODE_HI_ADDR: begin
                    prdata_next = mode_hi_reg;
                end
                le_ctrl_pkg::CTRL_ADDR: begin
                    prdata_next = ctrl_reg;
                end
                le_ctrl_pkg::STATUS_ADDR: begin
                    prdata_next = {17'h0_0000, chip_reset_n_s, ded_s, elem_q};
                end
                default: begin
                    prdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_lo_reg <= le_ctrl_pkg::MODE_RESET;
            mode_hi_reg <= le_ctrl_pkg::MODE_RESET;
            ctrl_reg    <= le_ctrl_pkg::CTRL_RESET;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            mode_lo_reg <= mode_lo_next;
            mode_hi_reg <= mode_hi_next;
            ctrl_reg    <= ctrl_next;
            prdata_reg  <= prdata_next;
        end
    end

    // global clear, preset, enable from dedicated inputs
    logic glob_clr_n;
    logic glob_pre_n;
    logic glob_cen;

    // Select codes six and seven leave the global line inactive
    always_comb begin
        glob_clr_n = 1'b1;
        glob_pre_n = 1'b1;
        glob_cen   = 1'b1;
        if (ctrl_reg.glob_clr_sel < 3'(le_ctrl_pkg::DED_COUNT)) begin
            glob_clr_n = ded_s[ctrl_reg.glob_clr_sel];
        end
        if (ctrl_reg.glob_pre_sel < 3'(le_ctrl_pkg::DED_COUNT)) begin
            glob_pre_n = ded_s[ctrl_reg.glob_pre_sel];
        end
        if (ctrl_reg.glob_cen_sel < 3'(le_ctrl_pkg::DED_COUNT)) begin
            glob_cen = ded_s[ctrl_reg.glob_cen_sel];
        end
    end

    // A disabled chip reset leaves each register to its own controls
    logic chip_reset_act;

    assign chip_reset_act = ctrl_reg.chip_reset_en && !chip_reset_n_s;

    // Per-element register with its clear and preset network
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_elem
            logic ld1;
            logic ld2;
            logic inv;
            logic prn;
            logic clrn;
            logic ld_val;
            logic has_pre;
            logic rst_ext;
            logic cen;

            // Global lines fold in, low-true, with each element's own line
            // only the two lines, each with its global line; no load data
            assign ld1 = !(pins_s[gi].block_control_line_first_n && glob_pre_n);
            assign ld2 = !(pins_s[gi].block_control_line_second_n && glob_clr_n);

            // mode selects primitive preset and clear
            always_comb begin
                inv     = 1'b0;
                prn     = 1'b1;
                clrn    = 1'b1;
                ld_val  = 1'b0;
                has_pre = 1'b0;
                case (cfg[gi].mode)
                    le_ctrl_pkg::MODE_CLEAR: begin
                        clrn = cfg[gi].clr_sel ? !ld2 : !ld1;
                    end
                    le_ctrl_pkg::MODE_PRESET: begin
                        has_pre = 1'b1;
                        if (cfg[gi].preset_inv) begin
                            inv  = 1'b1;
                            clrn = !ld1;
                        end else begin
                            prn = !ld1;
                        end
                    end
                    le_ctrl_pkg::MODE_CLEAR_PRESET: begin
                        has_pre = 1'b1;
                        prn     = !ld1;
                        clrn    = !ld2;
                    end
                    le_ctrl_pkg::MODE_LOAD_CLEAR: begin
                        // load via both, clear via second
                        ld_val = pins_s[gi].async_load_data_input;
                        prn    = !(ld1 && ld_val);
                        clrn   = !((ld1 && !ld_val) || ld2);
                    end
                    le_ctrl_pkg::MODE_LOAD_PRESET: begin
                        // inverted storage and load data
                        // Stored bit is the complement of what the pin shows
                        has_pre = 1'b1;
                        inv     = 1'b1;
                        ld_val  = !pins_s[gi].async_load_data_input;
                        prn     = !(ld1 && ld_val);
                        clrn    = !((ld1 && !ld_val) || ld2);
                    end
                    le_ctrl_pkg::MODE_LOAD_ONLY: begin
                        ld_val = pins_s[gi].async_load_data_input;
                        prn    = !(ld1 && ld_val);
                        clrn   = !(ld1 && !ld_val);
                    end
                    default: begin
                        inv = 1'b0;
                    end
                endcase
            end

            // preset-capable element may reset to one
            assign rst_ext = has_pre && cfg[gi].rst_one;
            assign cen = glob_cen &&
                         (!cfg[gi].cen_use || pins_s[gi].clock_enable_data_input);

            // Clear beats preset when both act; the pair is otherwise undefined
            always_comb begin
                store_next[gi] = store_reg[gi];
                if (chip_reset_act) begin
                    store_next[gi] = rst_ext ^ inv;
                end else if (!clrn) begin
                    store_next[gi] = 1'b0;
                end else if (!prn) begin
                    store_next[gi] = 1'b1;
                end else if (cen) begin
                    store_next[gi] = pins_s[gi].data_in ^ inv;
                end
            end

            // An inversion change shows at once; the stored bit stays
            assign elem_q[gi] = store_reg[gi] ^ inv;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Visible value after reset still follows the inversion setting
            store_reg <= '0;
        end else begin
            store_reg <= store_next;
        end
    end

endmodule // le_register_async_control

// ===== pin_driver.sv
`timescale 1ns/1ps
module pin_driver (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire le_ctrl_pkg::elem_pins_t [7:0] req,
    output le_ctrl_pkg::elem_pins_t [7:0]      elem_pins
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            elem_pins <= {8{5'h0B}};
        end else begin
            elem_pins <= req;
        end
    end
endmodule // pin_driver

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [7:0] d, ld, f, s, c, q;} row_t;
    logic                          pclk = 1'b0;
    logic                          presetn = 1'b0;
    logic                          psel = 1'b0;
    logic                          penable = 1'b0;
    logic                          pwrite = 1'b0;
    logic                          chip_reset_n = 1'b1;
    logic [7:0]                    paddr = 8'h00;
    logic [31:0]                   pwdata = 32'h0000_0000;
    logic [31:0]                   prdata, rd;
    logic                          pready, pslverr, er;
    logic [5:0]                    dedicated_in = 6'h3F;
    logic [5:0]                    dedicated_data;
    logic [7:0]                    elem_q;
    le_ctrl_pkg::elem_pins_t [7:0] req = {8{5'h0B}};
    le_ctrl_pkg::elem_pins_t [7:0] elem_pins;
    int                            miscompares = 0;
    int                            num_checks = 0;
    row_t rows [6] = '{
        '{8'hA5, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hA5}, '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hF4},
        '{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h16}, '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hCD},
        '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF, 8'hC4}, '{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hF7, 8'hF7}};
    always #5 pclk = ~pclk;
    pin_driver drv_u (.pclk, .presetn, .req, .elem_pins);
    le_register_async_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .elem_pins, .dedicated_in, .chip_reset_n, .elem_q,
        .dedicated_data);
    task automatic test_done();
        if (miscompares == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pins(input row_t r);
        @(posedge pclk);
        for (int e = 0; e < 8; e++) req[e] <= {r.d[e], r.c[e], r.ld[e], r.f[e], r.s[e]};
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        chk("reset_out", 32'h0000_3F00, {18'h0_0000, dedicated_data, elem_q});
        presetn <= 1'b1;
        apb(1'b0, le_ctrl_pkg::MODE_HI_ADDR, 32'h0000_0000);
        chk("mode_hi", le_ctrl_pkg::MODE_RESET, rd);
        apb(1'b0, le_ctrl_pkg::CTRL_ADDR, 32'h0000_0000);
        chk("ctrl", le_ctrl_pkg::CTRL_RESET, rd);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 32'h0000_0001, {rd[30:0], er});
        apb(1'b1, le_ctrl_pkg::STATUS_ADDR, 32'hFFFF_FFFF);
        chk("status_wr_err", 32'h0000_0000, {31'h0000_0000, er});
        apb(1'b1, le_ctrl_pkg::MODE_LO_ADDR, 32'h4001_0800);
        apb(1'b1, le_ctrl_pkg::MODE_HI_ADDR, 32'h0504_0302);
        apb(1'b0, le_ctrl_pkg::MODE_HI_ADDR, 32'h0000_0000);
        chk("mode_hi_rb", 32'h0504_0302, rd);
        foreach (rows[i]) begin
            pins(rows[i]);
            chk("elem_q", {24'h00_0000, rows[i].q}, {24'h00_0000, elem_q});
        end
        apb(1'b1, le_ctrl_pkg::MODE_LO_ADDR, 32'h4021_0800);
        apb(1'b1, le_ctrl_pkg::CTRL_ADDR, 32'h0000_0FFF);
        chip_reset_n <= 1'b0;
        pins('{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00});
        chk("chip_reset", 32'h0000_0004, {24'h00_0000, elem_q});
        chip_reset_n <= 1'b1;
        pins('{8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00});
        chk("after_reset", 32'h0000_00FF, {24'h00_0000, elem_q});
        apb(1'b1, le_ctrl_pkg::CTRL_ADDR, 32'h0000_0FF0);
        dedicated_in <= 6'h3E;
        repeat (6) @(posedge pclk);
        apb(1'b0, le_ctrl_pkg::STATUS_ADDR, 32'h0000_0000);
        chk("global_clear", 32'h0000_3ECD, {18'h0_0000, rd[13:0]});
        chk("ded_data", 32'h0000_003E, {26'h000_0000, dedicated_data});
        apb(1'b1, le_ctrl_pkg::MODE_LO_ADDR, 32'h4021_0811);
        pins('{8'h00, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'h45});
        chk("preset_inv", 32'h0000_0045, {24'h00_0000, elem_q});
        test_done();
    end
endmodule // testbench
